// ===== design/lcs_pkg.sv
// Constants and types shared by the charge sequencer
package lcs_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam logic [1:0] CUR_ZERO = 2'h0;
	localparam logic [1:0] CUR_TWENTIETH = 2'h1;
	localparam logic [1:0] CUR_TENTH = 2'h2;
	localparam logic [1:0] CUR_FULL = 2'h3;
	localparam int unsigned SYNC_STAGES = 2;
	// Bit positions in the comparator bundle
	localparam int unsigned CMP_N = 5;
	localparam int unsigned CMP_UV = 4;
	localparam int unsigned CMP_REG = 3;
	localparam int unsigned CMP_RECHG = 2;
	localparam int unsigned CMP_LOWCUR = 1;
	localparam int unsigned CMP_TEMP = 0;
	localparam int unsigned TMR_W = 40;
	localparam logic [TMR_W-1:0] TMR_ZERO = 40'h00_0000_0000;
	localparam logic [TMR_W-1:0] TMR_ONE = 40'h00_0000_0001;
	// Typical limits with 1 nF timing capacitors, in seconds
	localparam longint unsigned PREQ_S = 450;
	localparam longint unsigned FAST_S = 5400;
	localparam longint unsigned FULL_S = 5400;
	localparam longint unsigned TOPOFF_S = 2700;
	localparam longint unsigned PREQ_CYC = PREQ_S * CLK_HZ;
	localparam longint unsigned FAST_CYC = FAST_S * CLK_HZ;
	localparam longint unsigned FULL_CYC = FULL_S * CLK_HZ;
	localparam longint unsigned TOPOFF_CYC = TOPOFF_S * CLK_HZ;

	typedef enum logic [2:0] {
		ST_RESET = 3'h0,
		ST_PREQUAL = 3'h1,
		ST_FAST = 3'h2,
		ST_FULL = 3'h3,
		ST_TOPOFF = 3'h4,
		ST_DONE = 3'h5,
		ST_FAULT = 3'h6
	} lcs_state_type;
endpackage

// ===== design/lcs_tmr_if.sv
// Timer control and expiry bundle between sequencer and timers
`timescale 1ns/1ps
`default_nettype none
interface lcs_tmr_if;
	logic clear;
	logic run1;
	logic run2;
	logic [lcs_pkg::TMR_W-1:0] limit1;
	logic exp1;
	logic exp2;
	modport seq (output clear, output run1, output run2, output limit1, input exp1, input exp2);
	modport tmr (input clear, input run1, input run2, input limit1, output exp1, output exp2);
endinterface
`default_nettype wire

// ===== design/lcs_sync.sv
// Two-stage synchroniser for a bundle of comparator levels
`timescale 1ns/1ps
`default_nettype none
module lcs_sync #(
	parameter int unsigned W = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;
	logic [W-1:0] q_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= '0;
			q_r <= '0;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end
	assign q = q_r;
endmodule // lcs_sync
`default_nettype wire

// ===== design/lcs_timers.sv
// Two safety interval counters, one per timing capacitor
`timescale 1ns/1ps
`default_nettype none
module lcs_timers #(
	parameter longint unsigned FAST_CYC = lcs_pkg::FAST_CYC
) (
	input wire logic clk,
	input wire logic rst,
	lcs_tmr_if.tmr t
);
	localparam logic [lcs_pkg::TMR_W-1:0] FAST_LIM = lcs_pkg::TMR_W'(FAST_CYC);
	logic [lcs_pkg::TMR_W-1:0] cnt1_r;
	logic [lcs_pkg::TMR_W-1:0] cnt2_r;

	// No enable exists to switch these off; only clear and pause
	always_ff @(posedge clk) begin
		if (rst || t.clear) begin
			cnt1_r <= lcs_pkg::TMR_ZERO;
		end else if (t.run1 && cnt1_r < t.limit1) begin
			cnt1_r <= cnt1_r + lcs_pkg::TMR_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || t.clear) begin
			cnt2_r <= lcs_pkg::TMR_ZERO;
		end else if (t.run2 && cnt2_r < FAST_LIM) begin
			cnt2_r <= cnt2_r + lcs_pkg::TMR_ONE;
		end
	end

	assign t.exp1 = (cnt1_r >= t.limit1);
	assign t.exp2 = (cnt2_r >= FAST_LIM);
endmodule // lcs_timers
`default_nettype wire

// ===== design/lcs_sequencer.sv
// Lithium-ion charge algorithm state machine with safety timers
`timescale 1ns/1ps
`default_nettype none
// Function
// - Power-up or charge-disable release enters reset and zeroes all timers.
// - Reset always advances to prequalification.
// - Prequalification commands one twentieth of fast-charge current.
// - Leave prequal for fast only with voltage above threshold and temperature good.
// - Prequal timer expiry stops charging and pulls fault indicator low.
// - Prequal limit comes from the primary interval timer.
// - Bad temperature in prequal pauses charging and timer; both resume afterwards.
// - Fast charge pulls constant-current indicator low, charges at full current.
// - Reaching regulation voltage before fast timer expiry moves to full charge.
// - Fast timer expiry before voltage limit ends charging with fault.
// - Fast limit comes from the separate fast interval timer.
// - Bad temperature in fast charge pauses charging and timers.
// - Full charge pulls constant-voltage indicator low, regulates constant voltage.
// - Full charge goes to top-off on low current or full timer expiry.
// - Top-off charges at constant voltage until its timer expires, then done.
// - Done keeps charging off until recharge threshold, then back to reset.
// - Bad temperature in full or top-off pauses charging and timers.
// - Reset clears timers, zero current, all indicators high.
// - Fault leaves only by power cycle or charge disable low.
// - Safety timers are always active and cannot be disabled.
module lcs_sequencer #(
	parameter longint unsigned PREQ_CYC = lcs_pkg::PREQ_CYC,
	parameter longint unsigned FAST_CYC = lcs_pkg::FAST_CYC,
	parameter longint unsigned FULL_CYC = lcs_pkg::FULL_CYC,
	parameter longint unsigned TOPOFF_CYC = lcs_pkg::TOPOFF_CYC
) (
	// Clock and power-up reset
	input wire logic CLK,
	input wire logic RESET,
	// Charge disable, active low
	input wire logic CHARGE_DISABLE_INPUT_N,
	// Comparator results
	input wire logic BATT_ABOVE_UV,
	input wire logic BATT_AT_REG,
	input wire logic BATT_BELOW_RECHG,
	input wire logic CURRENT_BELOW_TENTH,
	input wire logic TEMP_IN_RANGE,
	// Charge current command
	output logic [1:0] CHARGE_CURRENT,
	output logic CONSTANT_VOLTAGE_MODE,
	// Open-drain indicators, enable high pulls the pin low
	output logic CONSTANT_CURRENT_INDICATOR_OE,
	output logic CONSTANT_VOLTAGE_INDICATOR_OE,
	output logic FAULT_INDICATOR_OE,
	output logic CONSTANT_CURRENT_INDICATOR_O,
	output logic CONSTANT_VOLTAGE_INDICATOR_O,
	output logic FAULT_INDICATOR_O,
	// State and pause status
	output logic [2:0] STATE,
	output logic TEMP_PAUSED
);
	localparam int unsigned NCMP = lcs_pkg::CMP_N;
	localparam logic [lcs_pkg::TMR_W-1:0] PREQ_LIM = lcs_pkg::TMR_W'(PREQ_CYC);
	localparam logic [lcs_pkg::TMR_W-1:0] FULL_LIM = lcs_pkg::TMR_W'(FULL_CYC);
	localparam logic [lcs_pkg::TMR_W-1:0] TOPOFF_LIM = lcs_pkg::TMR_W'(TOPOFF_CYC);

	lcs_pkg::lcs_state_type state_r;
	lcs_pkg::lcs_state_type state_nxt;

	// Comparator levels before and after synchronising
	logic [NCMP-1:0] cmp_raw;
	logic [NCMP-1:0] cmp_s;
	logic uv_ok;
	logic at_reg;
	logic rechg;
	logic low_cur;
	logic temp_ok;

	// Disable pin handling and shared hold conditions
	logic [1:0] en_sync_r;
	logic en_prev_r;
	logic enabled;
	logic restart;
	logic hold_rst;
	logic pause_nxt;

	// Registered outputs
	logic [1:0] cur_r;
	logic cv_r;
	logic cc_ind_r;
	logic cv_ind_r;
	logic fault_ind_r;
	logic paused_r;

	lcs_tmr_if tif ();

	// Phases in which bad temperature stops charging and timers
	function automatic logic active_phase(input lcs_pkg::lcs_state_type s);
		return (s == lcs_pkg::ST_PREQUAL) || (s == lcs_pkg::ST_FAST)
			|| (s == lcs_pkg::ST_FULL) || (s == lcs_pkg::ST_TOPOFF);
	endfunction

	always_comb begin
		cmp_raw = '0;
		cmp_raw[lcs_pkg::CMP_UV] = BATT_ABOVE_UV;
		cmp_raw[lcs_pkg::CMP_REG] = BATT_AT_REG;
		cmp_raw[lcs_pkg::CMP_RECHG] = BATT_BELOW_RECHG;
		cmp_raw[lcs_pkg::CMP_LOWCUR] = CURRENT_BELOW_TENTH;
		cmp_raw[lcs_pkg::CMP_TEMP] = TEMP_IN_RANGE;
	end
	lcs_sync #(.W(NCMP)) u_sync (
		.clk(CLK),
		.rst(RESET),
		.d(cmp_raw),
		.q(cmp_s)
	);
	assign uv_ok = cmp_s[lcs_pkg::CMP_UV];
	assign at_reg = cmp_s[lcs_pkg::CMP_REG];
	assign rechg = cmp_s[lcs_pkg::CMP_RECHG];
	assign low_cur = cmp_s[lcs_pkg::CMP_LOWCUR];
	assign temp_ok = cmp_s[lcs_pkg::CMP_TEMP];

	// Disable pin synchronised; reset value means disabled until seen high
	always_ff @(posedge CLK) begin
		if (RESET) begin
			en_sync_r <= 2'h0;
			en_prev_r <= 1'b0;
		end else begin
			en_sync_r <= {en_sync_r[0], CHARGE_DISABLE_INPUT_N};
			en_prev_r <= en_sync_r[1];
		end
	end

	assign enabled = en_sync_r[1];
	assign restart = enabled && !en_prev_r;
	// Power-up, disable low and the release cycle hold reset
	assign hold_rst = RESET || !enabled || restart;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			lcs_pkg::ST_RESET: begin
				state_nxt = lcs_pkg::ST_PREQUAL;
			end
			lcs_pkg::ST_PREQUAL: begin
				if (uv_ok && temp_ok) begin
					state_nxt = lcs_pkg::ST_FAST;
				end else if (tif.exp1) begin
					state_nxt = lcs_pkg::ST_FAULT;
				end
			end
			lcs_pkg::ST_FAST: begin
				if (temp_ok && at_reg) begin
					state_nxt = lcs_pkg::ST_FULL;
				end else if (tif.exp2) begin
					state_nxt = lcs_pkg::ST_FAULT;
				end
			end
			lcs_pkg::ST_FULL: begin
				if ((temp_ok && low_cur) || tif.exp1) begin
					state_nxt = lcs_pkg::ST_TOPOFF;
				end
			end
			lcs_pkg::ST_TOPOFF: begin
				if (tif.exp1) begin
					state_nxt = lcs_pkg::ST_DONE;
				end
			end
			lcs_pkg::ST_DONE: begin
				if (rechg) begin
					state_nxt = lcs_pkg::ST_RESET;
				end
			end
			lcs_pkg::ST_FAULT: begin
				state_nxt = lcs_pkg::ST_FAULT;
			end
			default: begin
				state_nxt = lcs_pkg::ST_RESET;
			end
		endcase
	end

	// Disable low or power-up reset holds reset, which are the only ways out of fault
	always_ff @(posedge CLK) begin
		if (hold_rst) begin
			state_r <= lcs_pkg::ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Timers cleared in reset and on every phase change
	assign tif.clear = hold_rst || (state_r == lcs_pkg::ST_RESET) || (state_nxt != state_r);

	// One counter serves three phases, so it must clear between them
	// Primary timer limit per phase
	always_comb begin
		case (state_r)
			lcs_pkg::ST_PREQUAL: tif.limit1 = PREQ_LIM;
			lcs_pkg::ST_FULL: tif.limit1 = FULL_LIM;
			default: tif.limit1 = TOPOFF_LIM;
		endcase
	end
	assign tif.run1 = temp_ok && active_phase(state_r) && (state_r != lcs_pkg::ST_FAST);
	// Fast timer runs only in fast charge
	assign tif.run2 = temp_ok && (state_r == lcs_pkg::ST_FAST);

	lcs_timers #(.FAST_CYC(FAST_CYC)) u_tmr (
		.clk(CLK),
		.rst(RESET),
		.t(tif)
	);

	assign pause_nxt = !temp_ok && active_phase(state_nxt);

	// Current command, registered from next state
	always_ff @(posedge CLK) begin
		if (hold_rst || pause_nxt) begin
			cur_r <= lcs_pkg::CUR_ZERO;
		end else begin
			case (state_nxt)
				lcs_pkg::ST_PREQUAL: cur_r <= lcs_pkg::CUR_TWENTIETH;
				lcs_pkg::ST_FAST: cur_r <= lcs_pkg::CUR_FULL;
				// Limit stays up, voltage loop governs
				lcs_pkg::ST_FULL: cur_r <= lcs_pkg::CUR_FULL;
				lcs_pkg::ST_TOPOFF: cur_r <= lcs_pkg::CUR_TENTH;
				default: cur_r <= lcs_pkg::CUR_ZERO;
			endcase
		end
	end

	// Constant voltage in full charge and top-off
	always_ff @(posedge CLK) begin
		if (hold_rst || pause_nxt) begin
			cv_r <= 1'b0;
		end else begin
			cv_r <= (state_nxt == lcs_pkg::ST_FULL) || (state_nxt == lcs_pkg::ST_TOPOFF);
		end
	end

	// Pause flag moves with the current command
	always_ff @(posedge CLK) begin
		if (hold_rst) begin
			paused_r <= 1'b0;
		end else begin
			paused_r <= pause_nxt;
		end
	end

	// Indicators keep their value through a pause, so they follow state only
	// Constant-current indicator
	always_ff @(posedge CLK) begin
		if (hold_rst) begin
			cc_ind_r <= 1'b0;
		end else begin
			cc_ind_r <= (state_nxt == lcs_pkg::ST_FAST);
		end
	end

	always_ff @(posedge CLK) begin
		if (hold_rst) begin
			cv_ind_r <= 1'b0;
		end else begin
			cv_ind_r <= (state_nxt == lcs_pkg::ST_FULL);
		end
	end

	always_ff @(posedge CLK) begin
		if (hold_rst) begin
			fault_ind_r <= 1'b0;
		end else begin
			fault_ind_r <= (state_nxt == lcs_pkg::ST_FAULT);
		end
	end

	assign CHARGE_CURRENT = cur_r;
	assign CONSTANT_VOLTAGE_MODE = cv_r;
	assign CONSTANT_CURRENT_INDICATOR_OE = cc_ind_r;
	assign CONSTANT_VOLTAGE_INDICATOR_OE = cv_ind_r;
	assign FAULT_INDICATOR_OE = fault_ind_r;
	assign CONSTANT_CURRENT_INDICATOR_O = 1'b0;
	assign CONSTANT_VOLTAGE_INDICATOR_O = 1'b0;
	assign FAULT_INDICATOR_O = 1'b0;
	assign STATE = state_r;
	assign TEMP_PAUSED = paused_r;
endmodule // lcs_sequencer
`default_nettype wire

// ===== bench/lcs_batt_model.sv
// Battery comparators and indicator pull-ups facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module lcs_batt_model (
	// Level 0 dead, 1 low, 2 charged, 3 at regulation
	input wire logic [1:0] level,
	input wire logic hot,
	input wire logic taper,
	// Indicator drive
	input wire logic [2:0] ind_oe,
	input wire logic [2:0] ind_o,
	// Comparators and pin levels
	output logic above_uv,
	output logic at_reg,
	output logic below_rechg,
	output logic cur_low,
	output logic temp_ok,
	output logic [2:0] pin
);
	assign above_uv = level != 2'h0;
	assign at_reg = level == 2'h3;
	assign below_rechg = level < 2'h2;
	assign cur_low = taper;
	assign temp_ok = !hot;
	// Pull-ups lift any indicator not pulled low
	assign pin = (ind_oe & ind_o) | ~ind_oe;
endmodule // lcs_batt_model
`default_nettype wire

// ===== bench/lcs_checker.sv
// Port assertions for the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module lcs_checker (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET,
	// Inputs
	input wire logic CHARGE_DISABLE_INPUT_N,
	input wire logic BATT_ABOVE_UV,
	input wire logic CURRENT_BELOW_TENTH,
	input wire logic TEMP_IN_RANGE,
	// Outputs
	input wire logic [1:0] CHARGE_CURRENT,
	input wire logic CONSTANT_VOLTAGE_MODE,
	input wire logic CONSTANT_CURRENT_INDICATOR_OE,
	input wire logic CONSTANT_VOLTAGE_INDICATOR_OE,
	input wire logic FAULT_INDICATOR_OE,
	input wire logic [2:0] STATE,
	input wire logic TEMP_PAUSED
);
	wire logic cc = CONSTANT_CURRENT_INDICATOR_OE;
	wire logic cv = CONSTANT_VOLTAGE_INDICATOR_OE;
	wire logic flt = FAULT_INDICATOR_OE;
	wire logic [1:0] cur = CHARGE_CURRENT;
	wire logic en = CHARGE_DISABLE_INPUT_N;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RESET);
	sequence s_enabled;
		en [*4] ##0 STATE == 3'h0;
	endsequence
	sequence s_to_fast;
		STATE == 3'h1 ##1 STATE == 3'h2;
	endsequence
	a_reset_quiet: assert property (STATE == 3'h0 |-> cur == 2'h0 && !cc && !cv && !flt)
		else $error("reset outputs active");
	a_reset_leave: assert property (s_enabled |-> ##[1:3] STATE == 3'h1)
		else $error("reset not left");
	a_disable_hold: assert property ((!en) [*4] |-> STATE == 3'h0)
		else $error("disable ignored");
	a_prequal_cur: assert property (STATE == 3'h1 && !TEMP_PAUSED |-> cur == 2'h1)
		else $error("prequal current");
	a_fast_entry: assert property (s_to_fast |-> $past(TEMP_IN_RANGE, 3) && $past(BATT_ABOVE_UV, 3))
		else $error("fast entry cause");
	a_pause_off: assert property (TEMP_PAUSED |-> cur == 2'h0 && !CONSTANT_VOLTAGE_MODE)
		else $error("paused but charging");
	a_fast_out: assert property (STATE == 3'h2 |-> cc && !cv && !flt && (TEMP_PAUSED || cur == 2'h3))
		else $error("fast outputs");
	a_full_out: assert property (STATE == 3'h3 |-> cv && !cc && (TEMP_PAUSED || CONSTANT_VOLTAGE_MODE))
		else $error("full outputs");
	a_taper_exit: assert property ((CURRENT_BELOW_TENTH && TEMP_IN_RANGE) [*3] ##0 STATE == 3'h3 |-> ##[1:2] STATE == 3'h4)
		else $error("no top-off on taper");
	a_topoff_out: assert property (STATE == 3'h4 |-> cur <= 2'h2 && !cc && !cv)
		else $error("top-off outputs");
	a_end_states: assert property (STATE == 3'h5 || STATE == 3'h6 |-> cur == 2'h0 && flt == (STATE == 3'h6))
		else $error("done or fault outputs");
	a_fault_stays: assert property (en [*3] ##0 STATE == 3'h6 |=> STATE == 3'h6)
		else $error("fault left");
endmodule // lcs_checker
`default_nettype wire

// ===== bench/testbench.sv
// Directed bench for the charge sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	localparam int PREQ = 20;
	localparam int FAST = 40;
	localparam int FULL = 30;
	localparam int TOP = 15;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic dis_n = 1'b1;
	logic [1:0] level = 2'h0;
	logic hot = 1'b0;
	logic taper = 1'b0;
	logic uv, at_reg, rechg, cur_low, temp_ok, cv_mode, paused;
	logic [1:0] cur;
	wire logic [2:0] oe, o;
	logic [2:0] pin, state;
	int bad_count = 0;
	int comparisons = 0;
	always #12.5 clk = ~clk;
	lcs_sequencer #(.PREQ_CYC(PREQ), .FAST_CYC(FAST), .FULL_CYC(FULL), .TOPOFF_CYC(TOP))
	i_lcs_sequencer (.CLK(clk), .RESET(rst), .CHARGE_DISABLE_INPUT_N(dis_n),
		.BATT_ABOVE_UV(uv), .BATT_AT_REG(at_reg), .BATT_BELOW_RECHG(rechg),
		.CURRENT_BELOW_TENTH(cur_low), .TEMP_IN_RANGE(temp_ok), .CHARGE_CURRENT(cur),
		.CONSTANT_VOLTAGE_MODE(cv_mode), .CONSTANT_CURRENT_INDICATOR_OE(oe[0]),
		.CONSTANT_VOLTAGE_INDICATOR_OE(oe[1]), .FAULT_INDICATOR_OE(oe[2]),
		.CONSTANT_CURRENT_INDICATOR_O(o[0]), .CONSTANT_VOLTAGE_INDICATOR_O(o[1]),
		.FAULT_INDICATOR_O(o[2]), .STATE(state), .TEMP_PAUSED(paused));
	lcs_batt_model i_lcs_batt_model (.level(level), .hot(hot), .taper(taper), .ind_oe(oe),
		.ind_o(o), .above_uv(uv), .at_reg(at_reg), .below_rechg(rechg), .cur_low(cur_low),
		.temp_ok(temp_ok), .pin(pin));
	task automatic drive(input logic [1:0] l, input logic h, input logic t, input int n);
		@(negedge clk);
		level = l;
		hot = h;
		taper = t;
		repeat (n) @(negedge clk);
	endtask
	task automatic check(input logic [2:0] s, input logic [1:0] c, input logic [2:0] p);
		comparisons++;
		if (state !== s || cur !== c || pin !== p) begin
			bad_count++;
			$display("unexpected at %0t: state %0d current %0d pins %b", $time, state, cur, pin);
		end
	endtask
	task automatic await(input logic [2:0] s, input int n);
		for (int i = 0; i < n && state !== s; i++) @(negedge clk);
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#50000;
		bad_count++;
		end_of_test();
	end
	initial begin
		repeat (8) @(negedge clk);
		check(3'h0, 2'h0, 3'h7);
		rst = 1'b0;
		await(3'h1, 8);
		check(3'h1, 2'h1, 3'h7);
		drive(2'h0, 1'b1, 1'b0, 4);
		check(3'h1, 2'h0, 3'h7);
		// Pause outlasts the limit, so a running timer would fault
		repeat (PREQ + 10) @(negedge clk);
		check(3'h1, 2'h0, 3'h7);
		drive(2'h0, 1'b0, 1'b0, 1);
		await(3'h6, PREQ + 8);
		check(3'h6, 2'h0, 3'h3);
		drive(2'h1, 1'b0, 1'b0, 10);
		check(3'h6, 2'h0, 3'h3);
		dis_n = 1'b0;
		repeat (6) @(negedge clk);
		check(3'h0, 2'h0, 3'h7);
		dis_n = 1'b1;
		await(3'h2, 12);
		check(3'h2, 2'h3, 3'h6);
		drive(2'h1, 1'b1, 1'b0, FAST + 5);
		check(3'h2, 2'h0, 3'h6);
		drive(2'h3, 1'b0, 1'b0, 1);
		await(3'h3, 8);
		check(3'h3, 2'h3, 3'h5);
		repeat (FULL - 8) @(negedge clk);
		check(3'h3, 2'h3, 3'h5);
		await(3'h4, 12);
		check(3'h4, 2'h2, 3'h7);
		repeat (TOP - 6) @(negedge clk);
		check(3'h4, 2'h2, 3'h7);
		await(3'h5, 10);
		check(3'h5, 2'h0, 3'h7);
		drive(2'h2, 1'b0, 1'b0, 8);
		check(3'h5, 2'h0, 3'h7);
		drive(2'h1, 1'b0, 1'b0, 0);
		await(3'h0, 8);
		check(3'h0, 2'h0, 3'h7);
		await(3'h2, 8);
		drive(2'h2, 1'b0, 1'b0, FAST - 8);
		check(3'h2, 2'h3, 3'h6);
		await(3'h6, 14);
		check(3'h6, 2'h0, 3'h3);
		drive(2'h3, 1'b0, 1'b1, 0);
		dis_n = 1'b0;
		repeat (6) @(negedge clk);
		dis_n = 1'b1;
		// Top-off well before the full limit proves the taper path
		await(3'h4, 20);
		check(3'h4, 2'h2, 3'h7);
		drive(2'h3, 1'b1, 1'b1, 4);
		check(3'h4, 2'h0, 3'h7);
		end_of_test();
	end
endmodule // testbench
bind lcs_sequencer lcs_checker i_lcs_checker (.CLK(CLK), .RESET(RESET),
	.CHARGE_DISABLE_INPUT_N(CHARGE_DISABLE_INPUT_N), .BATT_ABOVE_UV(BATT_ABOVE_UV),
	.CURRENT_BELOW_TENTH(CURRENT_BELOW_TENTH), .TEMP_IN_RANGE(TEMP_IN_RANGE),
	.CHARGE_CURRENT(CHARGE_CURRENT), .CONSTANT_VOLTAGE_MODE(CONSTANT_VOLTAGE_MODE),
	.CONSTANT_CURRENT_INDICATOR_OE(CONSTANT_CURRENT_INDICATOR_OE),
	.CONSTANT_VOLTAGE_INDICATOR_OE(CONSTANT_VOLTAGE_INDICATOR_OE),
	.FAULT_INDICATOR_OE(FAULT_INDICATOR_OE), .STATE(STATE), .TEMP_PAUSED(TEMP_PAUSED));
`default_nettype wire
